/* File: rtl/rx_fault_pkg.sv */
package rx_fault_pkg;

    // ------------------------------------------------------------
    // Bus target
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h68;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FAULT_PACKET_ENABLE_HI = 8'h00;
    localparam logic [7:0] OFS_FAULT_PACKET_ENABLE_LO = 8'h01;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE_HI = 8'h02;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE_LO = 8'h03;
    localparam logic [7:0] OFS_RAW_FAULT_STATUS_LO = 8'hd5;
    localparam logic [7:0] OFS_QUALIFIED_FAULT_HI = 8'hd6;
    localparam logic [7:0] OFS_QUALIFIED_FAULT_LO = 8'hd7;
    localparam logic [7:0] OFS_QUALIFIED_INTERRUPT_HI = 8'hd8;
    localparam logic [7:0] OFS_QUALIFIED_INTERRUPT_LO = 8'hd9;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FAULT_PACKET_ENABLE_HI = 8'h0f;
    localparam logic [7:0] RST_FAULT_PACKET_ENABLE_LO = 8'hff;
    localparam logic [7:0] RST_INTERRUPT_ENABLE_HI = 8'hff;
    localparam logic [7:0] RST_INTERRUPT_ENABLE_LO = 8'hff;

    // ------------------------------------------------------------
    // Field positions (low status bytes; thermal regulation bit 4 is in the high bytes)
    // ------------------------------------------------------------
    localparam int BIT_THERMISTOR_TWO = 7;
    localparam int BIT_THERMISTOR_ONE = 6;
    localparam int BIT_DIE_TEMP = 5;
    localparam int BIT_END_OF_CHARGE = 2;
    localparam int BIT_ENABLE_PIN = 0;
    localparam int BIT_THERMAL_REG = 4;
    localparam logic [7:0] LO_FAULT_MASK = 8'he5;

    // Condition vector order after the synchroniser
    localparam int NUM_COND = 6;
    localparam int COND_ENABLE_PIN = 0;
    localparam int COND_END_OF_CHARGE = 1;
    localparam int COND_DIE_TEMP = 2;
    localparam int COND_THERMISTOR_ONE = 3;
    localparam int COND_THERMISTOR_TWO = 4;
    localparam int COND_THERMAL_REG = 5;

    // ------------------------------------------------------------
    // End-of-power-transfer reason codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CHARGE_COMPLETE = 8'h01;
    localparam logic [7:0] CODE_INTERNAL_FAULT = 8'h02;
    localparam logic [7:0] CODE_OVER_TEMP = 8'h03;

    typedef enum logic [2:0] {
        TGT_IDLE = 3'b000,
        TGT_ADDR = 3'b001,
        TGT_ACK_ADDR = 3'b010,
        TGT_WRITE = 3'b011,
        TGT_ACK_WR = 3'b100,
        TGT_READ = 3'b101,
        TGT_ACK_RD = 3'b110
    } tgt_state_t;

endpackage

/* File: rtl/i2c_target.sv */
`timescale 1ns/100ps
`default_nettype none

module i2c_target
    import rx_fault_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    import rx_fault_pkg::*;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        tgt_state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic nack;
        logic sda_low;
        logic [7:0] ptr;
        logic wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } tgt_st_t;

    localparam tgt_st_t TGT_RESET = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
        state: TGT_IDLE, cnt: 4'h0, shift: 8'h00, rw: 1'b0,
        first: 1'b0, nack: 1'b0, sda_low: 1'b0, ptr: 8'h00,
        wr_stb: 1'b0, wr_addr: 8'h00, wr_data: 8'h00};

    tgt_st_t st_ff;
    tgt_st_t nxt_st;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise = st_ff.scl_s2 & ~st_ff.scl_d;
    assign scl_fall = ~st_ff.scl_s2 & st_ff.scl_d;
    assign start_cond = st_ff.scl_s2 & st_ff.sda_d & ~st_ff.sda_s2;
    assign stop_cond = st_ff.scl_s2 & ~st_ff.sda_d & st_ff.sda_s2;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_s1 = scl_in;
        nxt_st.scl_s2 = st_ff.scl_s1;
        nxt_st.scl_d = st_ff.scl_s2;
        nxt_st.sda_s1 = sda_in;
        nxt_st.sda_s2 = st_ff.sda_s1;
        nxt_st.sda_d = st_ff.sda_s2;
        nxt_st.wr_stb = 1'b0;
        if (start_cond) begin
            nxt_st.state = TGT_ADDR;
            nxt_st.cnt = 4'h0;
            nxt_st.sda_low = 1'b0;
        end else if (stop_cond) begin
            nxt_st.state = TGT_IDLE;
            nxt_st.sda_low = 1'b0;
        end else begin
            case (st_ff.state)
                TGT_ADDR, TGT_WRITE: begin
                    if (scl_rise) begin
                        nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_s2};
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall && st_ff.cnt == BITS_PER_BYTE) begin
                        if (st_ff.state == TGT_WRITE) begin
                            nxt_st.sda_low = 1'b1;
                            nxt_st.state = TGT_ACK_WR;
                            nxt_st.first = 1'b0;
                            if (st_ff.first) begin
                                nxt_st.ptr = st_ff.shift;
                            end else begin
                                nxt_st.wr_stb = 1'b1;
                                nxt_st.wr_addr = st_ff.ptr;
                                nxt_st.wr_data = st_ff.shift;
                                nxt_st.ptr = st_ff.ptr + 8'h01;
                            end
                        end else if (st_ff.shift[7:1] == TARGET_ADDR) begin
                            nxt_st.rw = st_ff.shift[0];
                            nxt_st.sda_low = 1'b1;
                            nxt_st.state = TGT_ACK_ADDR;
                        end else begin
                            nxt_st.state = TGT_IDLE;
                        end
                    end
                end
                TGT_ACK_ADDR, TGT_ACK_WR: begin
                    if (scl_fall) begin
                        nxt_st.cnt = 4'h0;
                        if (st_ff.state == TGT_ACK_ADDR && st_ff.rw) begin
                            nxt_st.shift = rd_data;
                            nxt_st.sda_low = ~rd_data[7];
                            nxt_st.state = TGT_READ;
                        end else begin
                            nxt_st.first = (st_ff.state == TGT_ACK_ADDR);
                            nxt_st.sda_low = 1'b0;
                            nxt_st.state = TGT_WRITE;
                        end
                    end
                end
                TGT_READ: begin
                    if (scl_fall) begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                        if (st_ff.cnt == LAST_TX_BIT) begin
                            nxt_st.sda_low = 1'b0;
                            nxt_st.state = TGT_ACK_RD;
                            nxt_st.ptr = st_ff.ptr + 8'h01;
                        end else begin
                            nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                            nxt_st.sda_low = ~st_ff.shift[6];
                        end
                    end
                end
                TGT_ACK_RD: begin
                    if (scl_rise) begin
                        nxt_st.nack = st_ff.sda_s2;
                    end else if (scl_fall) begin
                        if (st_ff.nack) begin
                            nxt_st.state = TGT_IDLE;
                        end else begin
                            nxt_st.cnt = 4'h0;
                            nxt_st.shift = rd_data;
                            nxt_st.sda_low = ~rd_data[7];
                            nxt_st.state = TGT_READ;
                        end
                    end
                end
                default: begin
                    nxt_st.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= TGT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = ~st_ff.sda_low;
    assign rd_addr = st_ff.ptr;
    assign wr_stb = st_ff.wr_stb;
    assign wr_addr = st_ff.wr_addr;
    assign wr_data = st_ff.wr_data;

endmodule

`default_nettype wire

/* File: rtl/rx_fault_interrupt_masking.sv */
// Behaviour
// - fault flag equals condition and packet enable
// - interrupt flag equals condition and interrupt enable
// - raw bit 2 follows end-of-charge pin
// - enable-pin fault sends packet code 0x02
// - either thermistor fault sends code 0x03
// - die temperature fault sends code 0x02
// - end-of-charge fault sends code 0x01
// - any interrupt flag asserts interrupt pin
// - packet enables at 0x01, thermistors bits 7,6
// - bit 5 gates die packet, resets one
// - bits 2 and 0 gate charge, enable-pin
// - 0x00 bit 4 gates thermal regulation, resets zero
// - interrupt enables at 0x03, thermistors bits 7,6
// - bits 5, 2 gate die, charge interrupts
// - bit 0 gates enable-pin interrupt, resets one
// - 0x02 bit 4 gates thermal regulation interrupt
// - raw bits 7,6,5 thermistors and die
// - codes: charge complete, internal fault, over temperature
// - bus target address 0x68
`timescale 1ns/100ps
`default_nettype none

module rx_fault_interrupt_masking
    import rx_fault_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic end_of_charge_in,
    input wire logic enable_pin_in,
    input wire logic thermistor_one_over,
    input wire logic thermistor_two_over,
    input wire logic die_over_temp,
    input wire logic thermal_reg_fault,
    output logic int_out,
    output logic int_oe_n,
    output logic power_transfer_end_packet_req,
    output logic [7:0] power_transfer_end_packet_code
);
    import rx_fault_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_COND-1:0] cond_s1;
        logic [NUM_COND-1:0] cond_s2;
        logic [7:0] raw_lo;
        logic raw_treg;
        logic [7:0] fen_hi;
        logic [7:0] fen_lo;
        logic [7:0] ien_hi;
        logic [7:0] ien_lo;
        logic [7:0] qf_lo;
        logic [7:0] qi_lo;
        logic qf_treg;
        logic qi_treg;
        logic [7:0] qf_prev;
        logic qf_treg_prev;
        logic ept_req;
        logic [7:0] ept_code;
        logic int_low;
    } flt_st_t;

    localparam flt_st_t FLT_RESET = '{
        cond_s1: '0, cond_s2: '0, raw_lo: 8'h00, raw_treg: 1'b0,
        fen_hi: RST_FAULT_PACKET_ENABLE_HI,
        fen_lo: RST_FAULT_PACKET_ENABLE_LO,
        ien_hi: RST_INTERRUPT_ENABLE_HI,
        ien_lo: RST_INTERRUPT_ENABLE_LO,
        qf_lo: 8'h00, qi_lo: 8'h00, qf_treg: 1'b0, qi_treg: 1'b0,
        qf_prev: 8'h00, qf_treg_prev: 1'b0, ept_req: 1'b0,
        ept_code: 8'h00, int_low: 1'b0};

    flt_st_t st_ff;
    flt_st_t nxt_st;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] trig_lo;
    logic trig_treg;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Reserved positions are forced to zero here, so they can
    // neither read back nor fire a packet or the interrupt.
    function automatic logic [7:0] qualify(input logic [7:0] raw,
                                           input logic [7:0] en);
        qualify = raw & en & LO_FAULT_MASK;
    endfunction

    function automatic logic [7:0] read_reg(input flt_st_t s,
                                            input logic [7:0] a);
        case (a)
            OFS_FAULT_PACKET_ENABLE_HI: read_reg = s.fen_hi;
            OFS_FAULT_PACKET_ENABLE_LO: read_reg = s.fen_lo;
            OFS_INTERRUPT_ENABLE_HI: read_reg = s.ien_hi;
            OFS_INTERRUPT_ENABLE_LO: read_reg = s.ien_lo;
            OFS_RAW_FAULT_STATUS_LO: read_reg = s.raw_lo;
            OFS_QUALIFIED_FAULT_LO: read_reg = s.qf_lo;
            OFS_QUALIFIED_INTERRUPT_LO: read_reg = s.qi_lo;
            // Upper flag bytes read zero; qf_treg and qi_treg are not mapped
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    i2c_target u_i2c_target (
        .mclk(mclk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    assign rd_data = read_reg(st_ff, rd_addr);

    // A flag that reaches the packet path this cycle but was clear the cycle before
    assign trig_lo = st_ff.qf_lo & ~st_ff.qf_prev;
    assign trig_treg = st_ff.qf_treg & ~st_ff.qf_treg_prev;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Analog comparators and pins are asynchronous to mclk
        nxt_st.cond_s1 = {thermal_reg_fault, thermistor_two_over,
                          thermistor_one_over, die_over_temp,
                          end_of_charge_in, enable_pin_in};
        nxt_st.cond_s2 = st_ff.cond_s1;

        nxt_st.raw_lo = 8'h00;
        nxt_st.raw_lo[BIT_THERMISTOR_TWO] =
            st_ff.cond_s2[COND_THERMISTOR_TWO];
        nxt_st.raw_lo[BIT_THERMISTOR_ONE] =
            st_ff.cond_s2[COND_THERMISTOR_ONE];
        nxt_st.raw_lo[BIT_DIE_TEMP] = st_ff.cond_s2[COND_DIE_TEMP];
        nxt_st.raw_lo[BIT_END_OF_CHARGE] =
            st_ff.cond_s2[COND_END_OF_CHARGE];
        nxt_st.raw_lo[BIT_ENABLE_PIN] = st_ff.cond_s2[COND_ENABLE_PIN];
        nxt_st.raw_treg = st_ff.cond_s2[COND_THERMAL_REG];

        // Flags are recomputed every cycle, never latched
        nxt_st.qf_lo = qualify(st_ff.raw_lo, st_ff.fen_lo);
        nxt_st.qi_lo = qualify(st_ff.raw_lo, st_ff.ien_lo);
        nxt_st.qf_treg = st_ff.raw_treg &
            st_ff.fen_hi[BIT_THERMAL_REG];
        nxt_st.qi_treg = st_ff.raw_treg &
            st_ff.ien_hi[BIT_THERMAL_REG];

        // Only the four enable bytes accept writes
        if (wr_stb) begin
            case (wr_addr)
                OFS_FAULT_PACKET_ENABLE_HI: nxt_st.fen_hi = wr_data;
                OFS_FAULT_PACKET_ENABLE_LO: nxt_st.fen_lo = wr_data;
                OFS_INTERRUPT_ENABLE_HI: nxt_st.ien_hi = wr_data;
                OFS_INTERRUPT_ENABLE_LO: nxt_st.ien_lo = wr_data;
                default: nxt_st.fen_hi = st_ff.fen_hi;
            endcase
        end

        // Packet request: one pulse per newly qualified fault.
        // Coincident faults send one packet, worst reason wins.
        nxt_st.qf_prev = st_ff.qf_lo;
        nxt_st.qf_treg_prev = st_ff.qf_treg;
        nxt_st.ept_req = (|trig_lo) | trig_treg;
        if (trig_lo[BIT_THERMISTOR_TWO] || trig_lo[BIT_THERMISTOR_ONE]) begin
            nxt_st.ept_code = CODE_OVER_TEMP;
        end else if (trig_lo[BIT_DIE_TEMP]) begin
            nxt_st.ept_code = CODE_INTERNAL_FAULT;
        end else if (trig_lo[BIT_ENABLE_PIN] || trig_treg) begin
            nxt_st.ept_code = CODE_INTERNAL_FAULT;
        end else if (trig_lo[BIT_END_OF_CHARGE]) begin
            nxt_st.ept_code = CODE_CHARGE_COMPLETE;
        end

        // Interrupt pin held while any interrupt flag stands
        nxt_st.int_low = (|st_ff.qi_lo) | st_ff.qi_treg;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= FLT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign int_out = 1'b0;
    assign int_oe_n = ~st_ff.int_low;
    assign power_transfer_end_packet_req = st_ff.ept_req;
    assign power_transfer_end_packet_code = st_ff.ept_code;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_fault_flag;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> st_ff.qf_lo ==
            ($past(st_ff.raw_lo) & $past(st_ff.fen_lo) & LO_FAULT_MASK);
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("qualified fault flag mismatch");

    property p_int_flag;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> st_ff.qi_lo ==
            ($past(st_ff.raw_lo) & $past(st_ff.ien_lo) & LO_FAULT_MASK);
    endproperty
    a_int_flag: assert property (p_int_flag)
        else $error("qualified interrupt flag mismatch");

    property p_eoc_raw;
        @(posedge mclk) disable iff (rst)
        end_of_charge_in [*5] |-> st_ff.raw_lo[BIT_END_OF_CHARGE];
    endproperty
    a_eoc_raw: assert property (p_eoc_raw)
        else $error("end of charge not seen in raw status");

    property p_therm_code;
        @(posedge mclk) disable iff (rst)
        ($rose(st_ff.qf_lo[BIT_THERMISTOR_TWO]) ||
         $rose(st_ff.qf_lo[BIT_THERMISTOR_ONE]))
        |=> st_ff.ept_req && st_ff.ept_code == CODE_OVER_TEMP;
    endproperty
    a_therm_code: assert property (p_therm_code)
        else $error("thermistor fault did not send over temperature");

    property p_enpin_code;
        @(posedge mclk) disable iff (rst)
        $rose(st_ff.qf_lo[BIT_ENABLE_PIN]) &&
        !st_ff.qf_lo[BIT_THERMISTOR_TWO] && !st_ff.qf_lo[BIT_THERMISTOR_ONE]
        |=> st_ff.ept_req && st_ff.ept_code == CODE_INTERNAL_FAULT;
    endproperty
    a_enpin_code: assert property (p_enpin_code)
        else $error("enable pin fault did not send internal fault");

    property p_die_code;
        @(posedge mclk) disable iff (rst)
        $rose(st_ff.qf_lo[BIT_DIE_TEMP]) &&
        !st_ff.qf_lo[BIT_THERMISTOR_TWO] && !st_ff.qf_lo[BIT_THERMISTOR_ONE]
        |=> st_ff.ept_req && st_ff.ept_code == CODE_INTERNAL_FAULT;
    endproperty
    a_die_code: assert property (p_die_code)
        else $error("die fault did not send internal fault");

    property p_eoc_code;
        @(posedge mclk) disable iff (rst)
        st_ff.ept_req && st_ff.ept_code == CODE_CHARGE_COMPLETE
        |-> $past(st_ff.qf_lo[BIT_END_OF_CHARGE]) &&
            !$past(trig_lo[BIT_ENABLE_PIN]);
    endproperty
    a_eoc_code: assert property (p_eoc_code)
        else $error("charge complete code without end of charge");

    property p_int_pin;
        @(posedge mclk) disable iff (rst)
        ((|st_ff.qi_lo) || st_ff.qi_treg) |=> !int_oe_n ##1 1'b1;
    endproperty
    a_int_pin: assert property (p_int_pin)
        else $error("interrupt pin not asserted");

    property p_int_idle;
        @(posedge mclk) disable iff (rst)
        (st_ff.qi_lo == 8'h00 && !st_ff.qi_treg) |=> int_oe_n;
    endproperty
    a_int_idle: assert property (p_int_idle)
        else $error("interrupt pin asserted without flag");

    property p_fen_write;
        @(posedge mclk) disable iff (rst)
        wr_stb && wr_addr == OFS_FAULT_PACKET_ENABLE_LO
        |=> st_ff.fen_lo == $past(wr_data);
    endproperty
    a_fen_write: assert property (p_fen_write)
        else $error("fault packet enable write lost");

    property p_ro_write;
        @(posedge mclk) disable iff (rst)
        wr_stb && wr_addr > OFS_INTERRUPT_ENABLE_LO
        |=> $stable(st_ff.fen_hi) && $stable(st_ff.fen_lo) &&
            $stable(st_ff.ien_hi) && $stable(st_ff.ien_lo);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to read-only address changed state");

    property p_treg_gate;
        @(posedge mclk) disable iff (rst)
        !st_ff.fen_hi[BIT_THERMAL_REG] |=> !st_ff.qf_treg;
    endproperty
    a_treg_gate: assert property (p_treg_gate)
        else $error("thermal regulation passed a cleared enable");

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        ((st_ff.qf_lo | st_ff.qi_lo) & ~LO_FAULT_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved flag bit set");

endmodule

`default_nettype wire

/* File: test/i2c_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
    import rx_fault_pkg::*;
(
    input wire logic mclk,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    // ----------------------------------------
    // Open-drain bus with pull-up
    // ----------------------------------------
    logic drv = 1'b1;
    initial scl = 1'b1;
    assign sda = drv & (sda_oe_n | sda_out);
    // One clock period of the bus; start, stop and data bits alike
    task automatic phase(input logic a, input logic b, input logic c,
            output logic r);
        repeat (5) @(posedge mclk);
        drv <= a;
        repeat (5) @(posedge mclk);
        scl <= 1'b1;
        repeat (5) @(posedge mclk);
        r = sda;
        drv <= b;
        repeat (5) @(posedge mclk);
        scl <= c;
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
            output logic a);
        for (int i = 7; i >= 0; i--)
            phase(d[i], d[i], 1'b0, q[i]);
        phase(1'b1, 1'b1, 1'b0, a);
    endtask
    // Reads end with a released ninth bit, so only one byte is taken
    task automatic xfer(input logic rd, input logic [7:0] p,
            input logic [7:0] v, output logic [7:0] q, output logic ok);
        logic [3:0] a;
        logic x;
        phase(1'b1, 1'b0, 1'b0, x);
        byte_io({TARGET_ADDR, 1'b0}, q, a[0]);
        byte_io(p, q, a[1]);
        if (rd)
            phase(1'b1, 1'b0, 1'b0, x);
        byte_io(rd ? {TARGET_ADDR, 1'b1} : v, q, a[2]);
        if (rd)
            byte_io(8'hff, q, a[3]);
        phase(1'b0, 1'b1, 1'b1, x);
        ok = ~|a[2:0];
    endtask
endmodule
`default_nettype wire

/* File: test/rx_fault_interrupt_masking_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module rx_fault_interrupt_masking_tb;
    import rx_fault_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda, so, soe, ioe, io, req, ok, m, tp, ei;
    logic [7:0] code, got, pc, raw, qf, ec;
    logic [5:0] c = 6'h00;
    logic [7:0] en [4] = '{8'h0f, 8'hff, 8'hff, 8'hff};
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int np = 0;
    int n0;
    initial forever #5 mclk = ~mclk;
    rx_fault_interrupt_masking rx_fault_interrupt_masking_i (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(so), .sda_oe_n(soe), .end_of_charge_in(c[1]),
        .enable_pin_in(c[0]), .thermistor_one_over(c[3]),
        .thermistor_two_over(c[4]), .die_over_temp(c[2]),
        .thermal_reg_fault(c[5]), .int_out(io), .int_oe_n(ioe),
        .power_transfer_end_packet_req(req),
        .power_transfer_end_packet_code(code)
    );
    i2c_host_model i2c_host_model_i (
        .mclk(mclk), .sda_out(so), .sda_oe_n(soe), .scl(scl), .sda(sda)
    );
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e,
            input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic r, input logic [7:0] p,
            input logic [7:0] v);
        i2c_host_model_i.xfer(r, p, v, got, ok);
    endtask
    // Worst reason wins when several faults rise together
    function automatic logic [7:0] exp_code(input logic [7:0] f,
            input logic t);
        if (|f[7:6])
            return CODE_OVER_TEMP;
        if (|{f[5], f[0], t})
            return CODE_INTERNAL_FAULT;
        return CODE_CHARGE_COMPLETE;
    endfunction
    // Enables must come back to defaults after every release
    task automatic reset_chk();
        rst <= 1'b1;
        en = '{8'h0f, 8'hff, 8'hff, 8'hff};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        for (int a = 0; a < 4; a++) begin
            bus(1'b1, 8'(a), 8'h00);
            chk("reset value", en[a], got);
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (req === 1'b1) begin
            np++;
            pc = code;
        end
        if (cyc == 80000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h79b2));
        reset_chk();
        // First pass all enabled, second all masked, then random
        for (int k = 0; k < 8; k++) begin
            c <= 6'h00;
            for (int a = 0; a < 4; a++) begin
                en[a] = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
                bus(1'b0, 8'(a), en[a]);
                chk("ack", 8'h01, {7'h00, ok});
            end
            bus(1'b0, OFS_QUALIFIED_FAULT_LO, 8'hff);
            @(posedge mclk);
            n0 = np;
            c <= k < 2 ? 6'h3f : 6'($urandom);
            repeat (12) @(posedge mclk);
            raw = {c[4:2], 2'b00, c[1], 1'b0, c[0]};
            qf = raw & en[1];
            tp = c[5] & en[0][4];
            m = |qf | tp;
            ec = exp_code(qf, tp);
            ei = ~(|(raw & en[3]) | (c[5] & en[2][4]));
            bus(1'b1, OFS_RAW_FAULT_STATUS_LO, 8'h00);
            chk("raw", raw, got);
            bus(1'b1, OFS_QUALIFIED_FAULT_LO, 8'h00);
            chk("fault flags", qf, got);
            bus(1'b1, OFS_QUALIFIED_INTERRUPT_LO, 8'h00);
            chk("int flags", raw & en[3], got);
            bus(1'b1, OFS_QUALIFIED_FAULT_HI, 8'h00);
            chk("fault hi", 8'h00, got);
            chk("int pin", {7'h00, ei}, {7'h00, ioe | io});
            chk("packets", 8'(m), 8'(np - n0));
            if (m)
                chk("code", ec, pc);
        end
        // Reset again in mid-run, faults left standing
        reset_chk();
        bus(1'b1, OFS_QUALIFIED_FAULT_LO, 8'h00);
        chk("fault flags", raw, got);
        end_sim();
    end
endmodule
`default_nettype wire
